// file: logic/chr_ctrl.sv
// horizontal readout timing generator for an interline ccd
`timescale 1ns/1ps
module chr_ctrl (
    // clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    // control
    input wire logic i_frame_start,
    input wire logic i_dual_mode,
    input wire logic i_line_req,
    input wire logic i_dump_line,
    input wire logic i_shutter_req,
    // status
    output logic o_busy,
    output logic o_image_valid,
    output logic o_dark_ref,
    output logic o_sample,
    output logic o_right_reverse,
    // sensor gates
    output logic o_left_storage_a,
    output logic o_left_storage_b,
    output logic o_left_barrier_a,
    output logic o_left_barrier_b,
    output logic o_right_storage_a,
    output logic o_right_storage_b,
    output logic o_right_barrier_a,
    output logic o_right_barrier_b,
    output logic o_left_last_phase,
    output logic o_right_last_phase,
    output logic o_left_reset_gate,
    output logic o_right_reset_gate,
    output logic o_vert_phase_a,
    output logic o_vert_phase_b,
    output logic o_fast_line_dump_gate,
    output logic o_shutter
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_VXFER = 4'h2,
        ST_WAIT = 4'h4,
        ST_SHIFT = 4'h8
    } chr_state_e;

    chr_state_e state_ff, nxt_state;
    logic dual_ff, nxt_dual;
    logic [12:0] pix_ff, nxt_pix;
    logic [4:0] sub_ff, nxt_sub;
    logic [9:0] wait_ff, nxt_wait;
    logic dump_ff, nxt_dump;
    logic ha_ff, nxt_ha;
    logic rst_ff, nxt_rst;
    logic samp_ff, nxt_samp;
    logic img_ff, nxt_img;
    logic dark_ff, nxt_dark;
    logic v_ff, nxt_v;
    logic fd_ff, nxt_fd;
    logic sh_ff, nxt_sh;

    function automatic logic in_range(input logic [12:0] p,
                                      input logic [12:0] lo,
                                      input logic [12:0] n);
        in_range = (p >= lo) && (p < 13'(lo + n));
    endfunction

    logic [12:0] line_len;
    logic [12:0] img_lo;
    logic [12:0] trail_lo;
    always_comb begin
        line_len = dual_ff ? chr_pkg::DUAL_LINE : chr_pkg::SGL_LINE;
        img_lo = 13'(chr_pkg::EMPTY_CELLS + chr_pkg::LEAD_DARK);
        trail_lo = 13'(img_lo + chr_pkg::SENSOR_IMAGE);
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_dual = dual_ff;
        nxt_pix = pix_ff;
        nxt_sub = sub_ff;
        nxt_wait = wait_ff;
        nxt_dump = dump_ff;
        nxt_ha = ha_ff;
        nxt_rst = 1'b0;
        nxt_samp = 1'b0;
        nxt_img = 1'b0;
        nxt_dark = 1'b0;
        nxt_v = 1'b0;
        nxt_fd = 1'b0;
        nxt_sh = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                nxt_ha = 1'b1;
                if (i_frame_start) begin
                    nxt_dual = i_dual_mode;
                end
                // shutter only pulsed while idle, never during shift
                nxt_sh = i_shutter_req;
                if (i_line_req && !i_frame_start) begin
                    nxt_state = ST_VXFER;
                    nxt_wait = '0;
                    nxt_dump = i_dump_line;
                end
            end
            ST_VXFER: begin
                nxt_ha = 1'b1;
                nxt_v = 1'b1;
                nxt_fd = dump_ff;
                nxt_wait = 10'(wait_ff + 10'h1);
                if (wait_ff == 10'(chr_pkg::VPULSE_CNT - 10'h1)) begin
                    nxt_v = 1'b0;
                    nxt_fd = 1'b0;
                    nxt_wait = '0;
                    nxt_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                nxt_ha = 1'b1;
                nxt_wait = 10'(wait_ff + 10'h1);
                if (wait_ff == 10'(chr_pkg::RESUME_CNT - 10'h1)) begin
                    // dumped line: register empty, nothing to read
                    nxt_state = dump_ff ? ST_IDLE : ST_SHIFT;
                    nxt_pix = '0;
                    nxt_sub = '0;
                end
            end
            ST_SHIFT: begin
                nxt_sub = 5'(sub_ff + 5'h1);
                nxt_ha = (sub_ff < chr_pkg::HALF_PIX);
                // reset after previous sample, before packet lands
                nxt_rst = (sub_ff < chr_pkg::RST_PULSE);
                nxt_samp = (sub_ff == chr_pkg::PIX_LAST);
                nxt_img = in_range(pix_ff, img_lo,
                    dual_ff ? chr_pkg::DUAL_IMAGE : chr_pkg::SGL_IMAGE);
                nxt_dark = in_range(pix_ff,
                    13'(chr_pkg::EMPTY_CELLS + chr_pkg::DARK_EDGE),
                    13'(chr_pkg::LEAD_DARK - chr_pkg::DARK_TRIM))
                    || (!dual_ff && in_range(pix_ff,
                    13'(trail_lo + chr_pkg::DARK_EDGE),
                    13'(chr_pkg::TRAIL_DARK - chr_pkg::DARK_TRIM)));
                if (sub_ff == chr_pkg::PIX_LAST) begin
                    nxt_sub = '0;
                    nxt_pix = 13'(pix_ff + 13'h1);
                    if (pix_ff == 13'(line_len - 13'h1)) begin
                        nxt_state = ST_IDLE;
                        nxt_ha = 1'b1;
                    end
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            state_ff <= ST_IDLE;
            dual_ff <= 1'b0;
            pix_ff <= '0;
            sub_ff <= '0;
            wait_ff <= '0;
            dump_ff <= 1'b0;
            ha_ff <= 1'b1;
            rst_ff <= 1'b0;
            samp_ff <= 1'b0;
            img_ff <= 1'b0;
            dark_ff <= 1'b0;
            v_ff <= 1'b0;
            fd_ff <= 1'b0;
            sh_ff <= 1'b0;
        end else if (i_clk_en) begin
            state_ff <= nxt_state;
            dual_ff <= nxt_dual;
            pix_ff <= nxt_pix;
            sub_ff <= nxt_sub;
            wait_ff <= nxt_wait;
            dump_ff <= nxt_dump;
            ha_ff <= nxt_ha;
            rst_ff <= nxt_rst;
            samp_ff <= nxt_samp;
            img_ff <= nxt_img;
            dark_ff <= nxt_dark;
            v_ff <= nxt_v;
            fd_ff <= nxt_fd;
            sh_ff <= nxt_sh;
        end
    end

    // storage, barrier and last-phase outputs registered from the same phase flop so edges align
    logic g_ff_busy;
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_left_storage_a <= 1'b1;
            o_left_storage_b <= 1'b0;
            o_left_barrier_a <= 1'b1;
            o_left_barrier_b <= 1'b0;
            o_right_storage_a <= 1'b1;
            o_right_storage_b <= 1'b0;
            o_right_barrier_a <= 1'b0;
            o_right_barrier_b <= 1'b1;
            o_left_last_phase <= 1'b1;
            o_right_last_phase <= 1'b1;
            o_left_reset_gate <= 1'b0;
            o_right_reset_gate <= 1'b0;
            o_vert_phase_a <= 1'b0;
            o_vert_phase_b <= 1'b0;
            o_fast_line_dump_gate <= 1'b0;
            o_shutter <= 1'b0;
            o_busy <= 1'b0;
            o_image_valid <= 1'b0;
            o_dark_ref <= 1'b0;
            o_sample <= 1'b0;
            o_right_reverse <= 1'b0;
        end else if (i_clk_en) begin
            o_left_storage_a <= ha_ff;
            o_left_storage_b <= !ha_ff;
            o_left_barrier_a <= ha_ff;
            o_left_barrier_b <= !ha_ff;
            o_right_storage_a <= ha_ff;
            o_right_storage_b <= !ha_ff;
            // right barriers inverted in logic per mode, same flop edge
            o_right_barrier_a <= dual_ff ? ha_ff : !ha_ff;
            o_right_barrier_b <= dual_ff ? !ha_ff : ha_ff;
            o_left_last_phase <= ha_ff;
            o_right_last_phase <= ha_ff;
            o_left_reset_gate <= rst_ff;
            o_right_reset_gate <= rst_ff && dual_ff;
            o_vert_phase_a <= v_ff;
            o_vert_phase_b <= v_ff;
            o_fast_line_dump_gate <= fd_ff;
            o_shutter <= sh_ff;
            o_busy <= state_ff != ST_IDLE;
            o_image_valid <= img_ff;
            o_dark_ref <= dark_ff;
            o_sample <= samp_ff;
            o_right_reverse <= dual_ff;
        end
    end
endmodule

// file: inc/chr_pkg.sv
// constants for the horizontal readout timing generator
package chr_pkg;
    localparam int CNT_W = 13;
    // per-line pixel counts and segment lengths
    localparam logic [12:0] EMPTY_CELLS = 13'h0004;
    localparam logic [12:0] LEAD_DARK = 13'h0014;
    localparam logic [12:0] SGL_IMAGE = 13'h0fc0;
    localparam logic [12:0] SGL_TRAIL_DARK = 13'h0014;
    localparam logic [12:0] SGL_LINE = 13'h0fec;
    localparam logic [12:0] DUAL_IMAGE = 13'h07e0;
    localparam logic [12:0] DUAL_LINE = 13'h07f8;
    // clean dark reference excludes first and last dark column
    localparam logic [12:0] DARK_EDGE = 13'h0001;
    localparam logic [12:0] DARK_TRIM = 13'h0002;
    // trailing dark cells sit after the full image span, not the clocked one
    localparam logic [12:0] SENSOR_IMAGE = 13'h0fc1;
    localparam logic [12:0] TRAIL_DARK = 13'h0013;
    // half-pixel phase length in ref clocks (24-clock pixel at 250 MHz)
    localparam logic [4:0] HALF_PIX = 5'h0c;
    localparam logic [4:0] PIX_LAST = 5'h17;
    // reset gate pulse occupies the first ticks of phase-a high
    localparam logic [4:0] RST_PULSE = 5'h03;
    // resume delay after vertical pulse falls, in ns
    localparam int RESUME_NS = 1000;
    localparam int CLK_NS = 4;
    localparam int RESUME_CYC = (RESUME_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [9:0] RESUME_CNT = 10'(RESUME_CYC);
    // vertical transfer pulse width in ns
    localparam int VPULSE_NS = 2000;
    localparam logic [9:0] VPULSE_CNT = 10'(VPULSE_NS / CLK_NS);
endpackage

// file: sim/chr_ctrl_assertions.sv
// port-level assertions for the readout timing generator
`timescale 1ns/1ps
module chr_ctrl_assertions (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // watched outputs
    input wire logic o_image_valid,
    input wire logic o_dark_ref,
    input wire logic o_right_reverse,
    input wire logic o_left_storage_a,
    input wire logic o_left_storage_b,
    input wire logic o_right_barrier_a,
    input wire logic o_right_barrier_b,
    input wire logic o_left_last_phase,
    input wire logic o_right_last_phase,
    input wire logic o_left_reset_gate,
    input wire logic o_vert_phase_a,
    input wire logic o_shutter,
    input wire logic o_fast_line_dump_gate,
    input wire logic o_left_barrier_a,
    input wire logic o_left_barrier_b,
    input wire logic o_right_storage_a,
    input wire logic o_right_storage_b,
    input wire logic o_right_reset_gate,
    input wire logic o_vert_phase_b
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_rst_pulse;
        o_left_reset_gate [*3] ##1 !o_left_reset_gate;
    endsequence
    chk_phase_split: assert property (
        o_left_storage_a != o_left_storage_b) else $error("phases overlap");
    chk_barrier_single: assert property (!o_right_reverse |->
        o_right_barrier_b == o_left_storage_a) else $error("single barrier");
    chk_barrier_dual: assert property (o_right_reverse |->
        o_right_barrier_a == o_left_storage_a) else $error("dual barrier");
    chk_last_phase: assert property (o_left_last_phase == o_left_storage_a
        && o_right_last_phase == o_left_storage_a) else $error("last phase");
    chk_vert_halt: assert property (o_vert_phase_a |->
        o_left_storage_a && !o_left_storage_b) else $error("not halted");
    // shifting must not resume before the settle delay has run out
    chk_resume_wait: assert property ($fell(o_vert_phase_a) |->
        o_left_storage_a throughout ##249 1'b1) else $error("early resume");
    chk_quiet_image: assert property (o_image_valid |-> !o_vert_phase_a
        && !o_shutter && !o_fast_line_dump_gate) else $error("noisy shift");
    chk_reset_pulse: assert property ($rose(o_left_reset_gate) |->
        s_rst_pulse) else $error("reset gate width");
    chk_dark_excl: assert property (
        !(o_dark_ref && o_image_valid)) else $error("dark in image");
    chk_left_barrier: assert property (
        o_left_barrier_a == o_left_storage_a
        && o_left_barrier_b == o_left_storage_b) else $error("left barrier");
    chk_right_storage: assert property (
        o_right_storage_a == o_left_storage_a
        && o_right_storage_b == o_left_storage_b) else $error("right storage");
    chk_right_reset: assert property (
        o_right_reset_gate == (o_left_reset_gate && o_right_reverse))
        else $error("right reset gate");
    chk_vert_pair: assert property (
        o_vert_phase_b == o_vert_phase_a) else $error("vertical pair");
endmodule
bind chr_ctrl chr_ctrl_assertions chk_i (.*);

// file: sim/chr_ccd_model.sv
// behavioural model of the sensor horizontal register
`timescale 1ns/1ps
module chr_ccd_model (
    // clock and clear
    input wire logic i_clk,
    input wire logic i_clear,
    // gate levels
    input wire logic i_stor_a,
    input wire logic i_stor_b,
    input wire logic i_bar_ra,
    input wire logic i_dump,
    // observations
    output int o_shifted,
    output logic o_right_out,
    output logic o_dumped
);
    logic prev_b;
    // right half runs to its own output when its barrier follows phase a
    assign o_right_out = (i_bar_ra == i_stor_a);
    always @(posedge i_clk) begin
        prev_b <= i_stor_b;
        if (i_clear) begin
            o_shifted <= 0;
            o_dumped <= 1'b0;
        end else begin
            o_dumped <= o_dumped | i_dump;
            o_shifted <= o_shifted + int'(i_stor_b && !prev_b);
        end
    end
endmodule

// file: sim/chr_ctrl_test.sv
// self-checking bench for the readout timing generator
`timescale 1ns/1ps
module chr_ctrl_test;
    typedef struct {logic dual; logic dump; logic [15:0] pix;
        logic [15:0] img; logic [15:0] dark;} chr_row_s;
    chr_row_s rows [3] = '{'{1'b0, 1'b1, 16'h0000, 16'h0000, 16'h0000},
        '{1'b1, 1'b1, 16'h0000, 16'h0000, 16'h0000},
        '{1'b1, 1'b0, 16'h07f8, 16'hbd00, 16'h01b0}};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic fs = 1'b0, dual = 1'b0, req = 1'b0, dump = 1'b0, shut = 1'b0;
    logic clr = 1'b1;
    logic en = 1'b1;
    logic busy, img, smp, rrev, sa, sb, bra, fdg, sht, rout, dmp, drk;
    int miscompares = 0;
    int n_checks = 0;
    int shifted, samples, images, shut_cnt, darks;
    always #2 clk = ~clk;
    chr_ctrl chr_ctrl_i (.i_ref_clk(clk), .i_rst_n(rst_n), .i_clk_en(en),
        .i_frame_start(fs), .i_dual_mode(dual), .i_line_req(req),
        .i_dump_line(dump), .i_shutter_req(shut), .o_busy(busy),
        .o_image_valid(img), .o_dark_ref(drk), .o_sample(smp),
        .o_right_reverse(rrev), .o_left_storage_a(sa), .o_left_storage_b(sb),
        .o_left_barrier_a(), .o_left_barrier_b(), .o_right_storage_a(),
        .o_right_storage_b(), .o_right_barrier_a(bra), .o_right_barrier_b(),
        .o_left_last_phase(), .o_right_last_phase(), .o_left_reset_gate(),
        .o_right_reset_gate(), .o_vert_phase_a(), .o_vert_phase_b(),
        .o_fast_line_dump_gate(fdg), .o_shutter(sht));
    chr_ccd_model chr_ccd_model_i (.i_clk(clk), .i_clear(clr), .i_stor_a(sa),
        .i_stor_b(sb), .i_bar_ra(bra), .i_dump(fdg), .o_shifted(shifted),
        .o_right_out(rout), .o_dumped(dmp));
    always @(posedge clk) begin
        samples <= clr ? 0 : samples + int'(smp);
        images <= clr ? 0 : images + int'(img);
        shut_cnt <= clr ? 0 : shut_cnt + int'(sht);
        darks <= clr ? 0 : darks + int'(drk);
    end
    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        n_checks++;
        if (exp !== got) begin
            miscompares++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic set_mode(logic d);
        @(posedge clk);
        dual <= d;
        fs <= 1'b1;
        clr <= 1'b1;
        @(posedge clk);
        fs <= 1'b0;
        clr <= 1'b0;
    endtask
    task automatic start_line(logic d);
        @(posedge clk);
        dump <= d;
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check("storage a", 1, sa);
        check("busy", 0, busy);
        $display("test reset done");
        foreach (rows[i]) begin
            set_mode(rows[i].dual);
            start_line(rows[i].dump);
            repeat (4) @(posedge clk);
            for (int k = 0; k < 60000 && busy === 1'b1; k++) @(posedge clk);
            // last sample pulse lands in the counters after busy falls
            repeat (4) @(posedge clk);
            check("dark cycles", rows[i].dark, 16'(darks));
            check("pixels", rows[i].pix, 16'(shifted));
            check("samples", rows[i].pix, 16'(samples));
            check("image cycles", rows[i].img, 16'(images));
            check("reverse", rows[i].dual, rrev);
            check("right out", rows[i].dual, rout);
            check("dump", rows[i].dump, dmp);
            $display("test row %0d done", i);
        end
        // single line cut short: a full one would outrun the time budget
        set_mode(1'b0);
        start_line(1'b0);
        repeat (1000) @(posedge clk);
        shut <= 1'b1;
        @(posedge clk);
        shut <= 1'b0;
        repeat (4) @(posedge clk);
        check("busy shutter", 0, 16'(shut_cnt));
        check("shifting", 1, 16'(shifted > 8));
        check("single out", 0, rout);
        rst_n <= 1'b0;
        clr <= 1'b1;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        clr <= 1'b0;
        @(posedge clk);
        check("busy after reset", 0, busy);
        shut <= 1'b1;
        @(posedge clk);
        shut <= 1'b0;
        repeat (6) @(posedge clk);
        check("idle shutter", 1, 16'(shut_cnt > 0));
        // enable low must swallow an idle shutter request
        en <= 1'b0;
        shut <= 1'b1;
        @(posedge clk);
        shut <= 1'b0;
        repeat (6) @(posedge clk);
        en <= 1'b1;
        check("frozen shutter", 1, 16'(shut_cnt));
        $display("test abort done");
        summarize();
    end
    initial begin
        repeat (70000) @(posedge clk);
        miscompares++;
        summarize();
    end
endmodule
